// ===== src/pptm_pkg.sv
// Package: register map, field positions and reset values of the pulse terminal mux
package pptm_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PPTM_OFS_CTRL  = 8'h00; // Method, enables, PWM selects
    localparam logic [7:0] PPTM_OFS_MODE  = 8'h04; // Operation mode, detection method
    localparam logic [7:0] PPTM_OFS_NOUT  = 8'h08; // Normal output levels
    localparam logic [7:0] PPTM_OFS_PINS  = 8'h0C; // Raw input terminals (read only)
    localparam logic [7:0] PPTM_OFS_OWNER = 8'h10; // Terminal ownership (read only)

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PPTM_CTRL_METH_LSB = 0;  // Per port: 0 CW/CCW, 1 pulse plus direction
    localparam int PPTM_CTRL_PEN_LSB  = 4;  // Per port: pulse output enable
    localparam int PPTM_CTRL_ORG_LSB  = 8;  // Per port: origin search enable
    localparam int PPTM_CTRL_PWM_LSB  = 12; // Per port: PWM on shared terminal 4/5
    localparam int PPTM_MODE_OPM_LSB  = 0;  // Per port 2 bits: operation mode
    localparam int PPTM_MODE_DET_LSB  = 8;  // Per port 2 bits: origin detection method
    localparam int PPTM_OWN_OUT_LSB   = 0;  // 12 bits: output terminal owned
    localparam int PPTM_OWN_IN_LSB    = 12; // 12 bits: input terminal owned
    localparam int PPTM_OWN_CONF_LSB  = 24; // 2 bits: method clash per module

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] PPTM_CTRL_RST = 16'h0000;
    localparam logic [15:0] PPTM_MODE_RST = 16'h0000;
    localparam logic [11:0] PPTM_NOUT_RST = 12'h000;
    localparam logic [1:0]  PPTM_OPM_0    = 2'h0;
    localparam logic [1:0]  PPTM_OPM_1    = 2'h1;
    localparam logic [1:0]  PPTM_OPM_2    = 2'h2;
    localparam logic [1:0]  PPTM_DET_1    = 2'h1;

endpackage

// ===== src/pptm_top.sv
// Pulse port terminal mux: routes four pulse ports onto two pulse I/O modules
// Functional notes
// - Per port CW/CCW or pulse plus direction
// - Output bits 00-03 carry pulses per method
// - Origin, proximity, positioning inputs by method/mode
// - Error counter reset on output bits 04/05
// - Error counter reset only in modes 1, 2
// - Each terminal carries exactly one function
// - Mode 0 frees bits 04/05 for PWM/normal
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module pptm_top
    import pptm_pkg::*;
(
    input  wire logic        pclk,          // APB clock, 125 MHz
    input  wire logic        presetn,       // Async reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error, unmapped address
    input  wire logic [3:0]  pulse_train,   // Pulse engine train per port
    input  wire logic [3:0]  pulse_busy,    // Pulse train in progress per port
    input  wire logic [3:0]  dir_ccw,       // Requested direction, 1 = CCW
    input  wire logic [3:0]  ecr_req,       // Error counter reset request
    input  wire logic [3:0]  pwm_level,     // PWM generator levels
    output logic      [3:0]  origin_sig,    // Origin input per port
    output logic      [3:0]  prox_sig,      // Proximity input per port
    output logic      [3:0]  inpos_sig,     // Positioning completed per port
    output logic      [11:0] normal_in,     // Free inputs, owned ones read 0
    input  wire logic        mod0_in_bit0,  // Module 0 input terminals
    input  wire logic        mod0_in_bit1,
    input  wire logic        mod0_in_bit2,
    input  wire logic        mod0_in_bit3,
    input  wire logic        mod0_in_bit4,
    input  wire logic        mod0_in_bit5,
    input  wire logic        mod1_in_bit0,  // Module 1 input terminals
    input  wire logic        mod1_in_bit1,
    input  wire logic        mod1_in_bit2,
    input  wire logic        mod1_in_bit3,
    input  wire logic        mod1_in_bit4,
    input  wire logic        mod1_in_bit5,
    output logic             mod0_out_bit0, // Module 0 output terminals
    output logic             mod0_out_bit1,
    output logic             mod0_out_bit2,
    output logic             mod0_out_bit3,
    output logic             mod0_out_bit4,
    output logic             mod0_out_bit5,
    output logic             mod1_out_bit0, // Module 1 output terminals
    output logic             mod1_out_bit1,
    output logic             mod1_out_bit2,
    output logic             mod1_out_bit3,
    output logic             mod1_out_bit4,
    output logic             mod1_out_bit5
);

    // ------------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] mode_q;
    logic [11:0] nout_q;
    logic [3:0]  dir_hold_q;
    logic [11:0] out_q;
    logic [11:0] out_d;
    logic [11:0] pin_in;
    logic [11:0] own_out;
    logic [11:0] own_in;
    logic [1:0]  clash;
    logic [3:0]  origin_d;
    logic [3:0]  prox_d;
    logic [3:0]  inpos_d;
    logic [3:0]  meth_pd;
    logic [3:0]  pen;
    logic [3:0]  org_en;
    logic [3:0]  pwm_sel;
    logic [3:0]  ecr_on;
    logic [3:0]  prox_on;
    logic [3:0]  inpos_on;
    logic [3:0]  cw;
    logic [3:0]  ccw;
    logic [31:0] rdata_d;
    logic        bus_acc;
    logic        hit;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign bus_acc = psel & penable;
    assign hit     = (paddr == PPTM_OFS_CTRL) | (paddr == PPTM_OFS_MODE)
                   | (paddr == PPTM_OFS_NOUT) | (paddr == PPTM_OFS_PINS)
                   | (paddr == PPTM_OFS_OWNER);

    // Read mux, unused bits read zero
    assign rdata_d = (paddr == PPTM_OFS_CTRL)  ? {16'h0000, ctrl_q} :
                     (paddr == PPTM_OFS_MODE)  ? {16'h0000, mode_q} :
                     (paddr == PPTM_OFS_NOUT)  ? {20'h00000, nout_q} :
                     (paddr == PPTM_OFS_PINS)  ? {20'h00000, pin_in} :
                     (paddr == PPTM_OFS_OWNER) ? {6'h00, clash, own_in, own_out} :
                                                 32'h0000_0000;

    // Setup cycle preloads read data and answer; access completes with zero wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= rdata_d;
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
        end
    end

    // Software writes, taken at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= PPTM_CTRL_RST;
            mode_q <= PPTM_MODE_RST;
            nout_q <= PPTM_NOUT_RST;
        end else if (bus_acc && pready && pwrite) begin
            if (paddr == PPTM_OFS_CTRL) ctrl_q <= pwdata[15:0];
            if (paddr == PPTM_OFS_MODE) mode_q <= pwdata[15:0];
            if (paddr == PPTM_OFS_NOUT) nout_q <= pwdata[11:0];
        end
    end

    // ------------------------------------------------------------------
    // Per port function decode
    // ------------------------------------------------------------------
    assign pin_in = {mod1_in_bit5, mod1_in_bit4, mod1_in_bit3, mod1_in_bit2,
                     mod1_in_bit1, mod1_in_bit0, mod0_in_bit5, mod0_in_bit4,
                     mod0_in_bit3, mod0_in_bit2, mod0_in_bit1, mod0_in_bit0};

    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_port
            assign meth_pd[p]  = ctrl_q[PPTM_CTRL_METH_LSB + p];
            assign pen[p]      = ctrl_q[PPTM_CTRL_PEN_LSB + p];
            assign org_en[p]   = ctrl_q[PPTM_CTRL_ORG_LSB + p];
            assign pwm_sel[p]  = ctrl_q[PPTM_CTRL_PWM_LSB + p];
            // Reset output only in modes 1 and 2
            assign ecr_on[p]   = org_en[p]
                & ((mode_q[PPTM_MODE_OPM_LSB + 2*p +: 2] == PPTM_OPM_1)
                 | (mode_q[PPTM_MODE_OPM_LSB + 2*p +: 2] == PPTM_OPM_2));
            assign prox_on[p]  = org_en[p]
                & (mode_q[PPTM_MODE_DET_LSB + 2*p +: 2] <= PPTM_DET_1);
            assign inpos_on[p] = org_en[p]
                & (mode_q[PPTM_MODE_OPM_LSB + 2*p +: 2] == PPTM_OPM_2);
            // Direction from the held level so it cannot flip mid train
            assign cw[p]  = pulse_train[p] & ~dir_hold_q[p];
            assign ccw[p] = pulse_train[p] & dir_hold_q[p];

            // Direction tracks request only while no train is running
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_hold_q[p] <= 1'b0;
                end else if (!pulse_busy[p]) begin
                    dir_hold_q[p] <= dir_ccw[p];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Per module terminal routing
    // ------------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < 2; m++) begin : g_mod
            localparam int A = 2*m;
            localparam int B = 2*m + 1;
            localparam int T = 6*m;
            logic cwa;
            logic cwb;
            logic pda;
            logic pdb;
            assign cwa = pen[A] & ~meth_pd[A];
            assign cwb = pen[B] & ~meth_pd[B];
            assign pda = pen[A] & meth_pd[A];
            assign pdb = pen[B] & meth_pd[B];

            // Ownership of output terminals; normal output only when unowned
            assign own_out[T+0] = pen[A];
            assign own_out[T+1] = cwa | pdb;
            assign own_out[T+2] = cwb | pda;
            assign own_out[T+3] = pen[B];
            assign own_out[T+4] = ecr_on[A] | pwm_sel[A];
            assign own_out[T+5] = ecr_on[B] | pwm_sel[B];
            // Mixed methods in one module would want the same terminal twice
            assign clash[m] = (cwa & pdb) | (pda & cwb);

            // Pulse terminals: CW/CCW pairs or pulse/pulse/dir/dir
            assign out_d[T+0] = pen[A] ? (meth_pd[A] ? pulse_train[A] : cw[A])
                                       : nout_q[T+0];
            assign out_d[T+1] = cwa ? ccw[A] : pdb ? pulse_train[B] : nout_q[T+1];
            assign out_d[T+2] = cwb ? cw[B] : pda ? dir_hold_q[A] : nout_q[T+2];
            assign out_d[T+3] = pen[B] ? (meth_pd[B] ? dir_hold_q[B] : ccw[B])
                                       : nout_q[T+3];
            // Reset outputs; else PWM or normal as software picks
            assign out_d[T+4] = ecr_on[A] ? ecr_req[A]
                              : pwm_sel[A] ? pwm_level[A] : nout_q[T+4];
            assign out_d[T+5] = ecr_on[B] ? ecr_req[B]
                              : pwm_sel[B] ? pwm_level[B] : nout_q[T+5];

            // Input terminals for origin search
            assign origin_d[A] = org_en[A] & pin_in[T+0];
            assign prox_d[A]   = prox_on[A] & pin_in[T+1];
            assign origin_d[B] = org_en[B] & pin_in[T+2];
            assign prox_d[B]   = prox_on[B] & pin_in[T+3];
            assign inpos_d[A]  = inpos_on[A] & pin_in[T+4];
            assign inpos_d[B]  = inpos_on[B] & pin_in[T+5];
            assign own_in[T+0] = org_en[A];
            assign own_in[T+1] = prox_on[A];
            assign own_in[T+2] = org_en[B];
            assign own_in[T+3] = prox_on[B];
            assign own_in[T+4] = inpos_on[A];
            assign own_in[T+5] = inpos_on[B];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Terminal and signal flops
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q      <= 12'h000;
            origin_sig <= 4'h0;
            prox_sig   <= 4'h0;
            inpos_sig  <= 4'h0;
            normal_in  <= 12'h000;
        end else begin
            out_q      <= out_d;
            origin_sig <= origin_d;
            prox_sig   <= prox_d;
            inpos_sig  <= inpos_d;
            normal_in  <= pin_in & ~own_in;
        end
    end

    assign mod0_out_bit0 = out_q[0];
    assign mod0_out_bit1 = out_q[1];
    assign mod0_out_bit2 = out_q[2];
    assign mod0_out_bit3 = out_q[3];
    assign mod0_out_bit4 = out_q[4];
    assign mod0_out_bit5 = out_q[5];
    assign mod1_out_bit0 = out_q[6];
    assign mod1_out_bit1 = out_q[7];
    assign mod1_out_bit2 = out_q[8];
    assign mod1_out_bit3 = out_q[9];
    assign mod1_out_bit4 = out_q[10];
    assign mod1_out_bit5 = out_q[11];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_METHOD_SEL: assert property (
        pen[0] && !meth_pd[0] |=> mod0_out_bit0 == $past(pulse_train[0] & ~dir_hold_q[0]))
        else $error("port 0 CW terminal wrong in CW/CCW method");
    AST_PD_PULSE: assert property (
        pen[3] && meth_pd[3] && !(pen[2] && !meth_pd[2])
        |=> mod1_out_bit1 == $past(pulse_train[3]))
        else $error("port 3 pulse not on module 1 bit 1");
    AST_PD_DIR: assert property (
        pen[1] && meth_pd[1] |=> mod0_out_bit3 == $past(dir_hold_q[1]))
        else $error("port 1 direction not on module 0 bit 3");
    AST_ORIGIN_IN: assert property (
        org_en[2] |=> origin_sig[2] == $past(mod1_in_bit0))
        else $error("port 2 origin input not taken");
    AST_PROX_GATE: assert property (
        org_en[1] && mode_q[11:10] > PPTM_DET_1 |=> !prox_sig[1])
        else $error("proximity used with wrong detection method");
    AST_ECR_OUT: assert property (
        ecr_on[1] |=> mod0_out_bit5 == $past(ecr_req[1]))
        else $error("port 1 error counter reset not on bit 5");
    AST_ECR_MODE0: assert property (
        org_en[2] && mode_q[5:4] == PPTM_OPM_0 && !pwm_sel[2]
        |=> mod1_out_bit4 == $past(nout_q[10]))
        else $error("error counter reset driven in mode 0");
    AST_PWM_FREE: assert property (
        !ecr_on[0] && pwm_sel[0] |=> mod0_out_bit4 == $past(pwm_level[0]))
        else $error("PWM not on freed terminal");
    AST_NORMAL_MASK: assert property (
        org_en[0] |=> !normal_in[0])
        else $error("origin terminal also seen as normal input");
    AST_DIR_HOLD: assert property (
        pulse_busy[3] && $past(pulse_busy[3]) |-> $stable(dir_hold_q[3]))
        else $error("direction changed during pulse train");

    COV_CW_TRAIN: cover property (pen[0] && !meth_pd[0] && pulse_train[0] ##1 mod0_out_bit0);
    COV_PD_TRAIN: cover property (pen[2] && meth_pd[2] && pulse_busy[2] [*3]);
    COV_ECR:      cover property (ecr_on[3] && ecr_req[3] ##1 mod1_out_bit5);
    COV_CLASH:    cover property (clash[0]);

endmodule // pptm_top

// ===== verif/pptm_drive.sv
// Drive side model: sensor levels onto input terminals, pulse counting on port 0
`timescale 1ns/1ns
module pptm_drive (
    input  wire logic        pclk,    // Scan clock
    input  wire logic [11:0] sense,   // Sensor levels, bit 6m+k
    input  wire logic        cw,      // Port 0 CW or pulse terminal
    input  wire logic        ccw,     // Port 0 CCW terminal
    output logic      [11:0] in_bits, // Levels onto the input terminals
    output logic      [7:0]  cw_cnt,  // Rising edges seen on cw
    output logic      [7:0]  ccw_cnt  // Rising edges seen on ccw
);
    logic       cw_q  = 1'b0;
    logic       ccw_q = 1'b0;
    logic [7:0] cw_n  = 8'h00;
    logic [7:0] ccw_n = 8'h00;

    // Sensors are wired straight to the terminals
    assign in_bits = sense;
    assign cw_cnt  = cw_n;
    assign ccw_cnt = ccw_n;

    // Count pulses the way a drive input stage would
    always @(posedge pclk) begin
        cw_q  <= cw;
        ccw_q <= ccw;
        if (cw === 1'b1 && cw_q === 1'b0) cw_n <= cw_n + 8'h01;
        if (ccw === 1'b1 && ccw_q === 1'b0) ccw_n <= ccw_n + 8'h01;
    end
endmodule // pptm_drive

// ===== verif/pptm_top_test.sv
// Self-checking bench of the pulse port terminal mux
`timescale 1ns/1ns
module pptm_top_test;
    import pptm_pkg::*;

    typedef struct {
        logic [15:0] ctrl, mode;
        logic [11:0] nout;
        logic [3:0]  train, dir, ecr, pwm;
        logic [11:0] pins, outv;
        logic [3:0]  org, prox, inp;
        logic [11:0] nin;
    } pptm_row_s;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic        err_q;
    logic [3:0]  train, busy, dir, ecr, pwm, org, prox, inp;
    logic [11:0] pins, nin, inb, o;
    logic [7:0]  cwc, ccwc;
    logic [7:0]  cw0, ccw0;
    int          num_errors, n_checks;
    pptm_row_s   rows [5];

    // -----------------------------------------------------------------
    // Design and drive model
    // -----------------------------------------------------------------
    pptm_top i_pptm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_train(train), .pulse_busy(busy), .dir_ccw(dir),
        .ecr_req(ecr), .pwm_level(pwm), .origin_sig(org), .prox_sig(prox),
        .inpos_sig(inp), .normal_in(nin),
        .mod0_in_bit0(inb[0]), .mod0_in_bit1(inb[1]), .mod0_in_bit2(inb[2]),
        .mod0_in_bit3(inb[3]), .mod0_in_bit4(inb[4]), .mod0_in_bit5(inb[5]),
        .mod1_in_bit0(inb[6]), .mod1_in_bit1(inb[7]), .mod1_in_bit2(inb[8]),
        .mod1_in_bit3(inb[9]), .mod1_in_bit4(inb[10]), .mod1_in_bit5(inb[11]),
        .mod0_out_bit0(o[0]), .mod0_out_bit1(o[1]), .mod0_out_bit2(o[2]),
        .mod0_out_bit3(o[3]), .mod0_out_bit4(o[4]), .mod0_out_bit5(o[5]),
        .mod1_out_bit0(o[6]), .mod1_out_bit1(o[7]), .mod1_out_bit2(o[8]),
        .mod1_out_bit3(o[9]), .mod1_out_bit4(o[10]), .mod1_out_bit5(o[11]));
    pptm_drive i_pptm_drive (.pclk(pclk), .sense(pins), .cw(o[0]), .ccw(o[1]),
        .in_bits(inb), .cw_cnt(cwc), .ccw_cnt(ccwc));

    always #4 pclk = ~pclk;

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q  = prdata;
        err_q = pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run of under two hundred cycles
    initial begin
        #200000;
        num_errors++;
        summarize();
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        pclk       = 0;
        presetn    = 0;
        psel       = 0;
        penable    = 0;
        pwrite     = 0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        train      = 4'h0;
        busy       = 4'h0;
        dir        = 4'h0;
        ecr        = 4'h0;
        pwm        = 4'h0;
        pins       = 12'h000;
        num_errors = 0;
        n_checks   = 0;
        // Free terminals, CW/CCW, pulse plus direction, origin modes, mode 0 with PWM
        rows[0] = '{16'h0000, 16'h0000, 12'hFFF, 4'h0, 4'h0, 4'h0, 4'h0, 12'hABC,
                    12'hFFF, 4'h0, 4'h0, 4'h0, 12'hABC};
        rows[1] = '{16'h00F0, 16'h0000, 12'hFFF, 4'hF, 4'hA, 4'h0, 4'h0, 12'h000,
                    12'hE79, 4'h0, 4'h0, 4'h0, 12'h000};
        rows[2] = '{16'h00FF, 16'h0000, 12'h000, 4'h5, 4'h9, 4'h0, 4'h0, 12'h000,
                    12'h245, 4'h0, 4'h0, 4'h0, 12'h000};
        rows[3] = '{16'h0F00, 16'hC989, 12'h000, 4'h0, 4'h0, 4'hF, 4'hF, 12'hFFF,
                    12'h830, 4'hF, 4'h5, 4'hA, 12'h618};
        rows[4] = '{16'hFF00, 16'h0000, 12'h000, 4'h0, 4'h0, 4'hF, 4'h6, 12'hFFF,
                    12'h420, 4'hF, 4'hF, 4'h0, 12'hC30};
        idle(2);
        chk(32'(o), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PPTM_OFS_CTRL, 32'h0);
        chk(rd_q, 32'(PPTM_CTRL_RST));
        apb(1'b0, PPTM_OFS_MODE, 32'h0);
        chk(rd_q, 32'(PPTM_MODE_RST));
        apb(1'b0, PPTM_OFS_NOUT, 32'h0);
        chk(rd_q, 32'(PPTM_NOUT_RST));
        apb(1'b0, 8'h14, 32'h0);
        chk(rd_q, 32'h0);
        chk(32'(err_q), 32'h1);
        $display("test reset and register access done");

        // Table of terminal assignments
        foreach (rows[i]) begin
            apb(1'b1, PPTM_OFS_CTRL, {16'h0, rows[i].ctrl});
            apb(1'b1, PPTM_OFS_MODE, {16'h0, rows[i].mode});
            apb(1'b1, PPTM_OFS_NOUT, {20'h0, rows[i].nout});
            train <= rows[i].train;
            dir   <= rows[i].dir;
            ecr   <= rows[i].ecr;
            pwm   <= rows[i].pwm;
            pins  <= rows[i].pins;
            idle(4);
            chk(32'(o), 32'(rows[i].outv));
            chk(32'({org, prox, inp}), 32'({rows[i].org, rows[i].prox, rows[i].inp}));
            chk(32'(nin), 32'(rows[i].nin));
            $display("test row %0d done", i);
        end
        apb(1'b0, PPTM_OFS_CTRL, 32'h0);
        chk(rd_q, 32'h0000FF00);
        chk(32'(err_q), 32'h0);
        apb(1'b0, PPTM_OFS_OWNER, 32'h0);
        chk(rd_q, 32'h003CFC30);
        apb(1'b0, PPTM_OFS_PINS, 32'h0);
        chk(rd_q, 32'h00000FFF);
        // Mixed methods in module 0 flag a clash
        apb(1'b1, PPTM_OFS_CTRL, 32'h0000_0031);
        apb(1'b0, PPTM_OFS_OWNER, 32'h0);
        chk(rd_q, 32'h0100000D);
        $display("test ownership done");

        // Pulse trains counted by the drive, CW then CCW
        apb(1'b1, PPTM_OFS_CTRL, 32'h0000_0010);
        ecr  <= 4'h0;
        pins <= 12'h000;
        dir  <= 4'h0;
        cw0  = cwc;
        ccw0 = ccwc;
        for (int k = 0; k < 10; k++) begin
            if (k == 5) dir <= 4'h1;
            repeat (2) @(posedge pclk);
            train <= 4'h1;
            repeat (2) @(posedge pclk);
            train <= 4'h0;
        end
        idle(3);
        chk(32'({cwc - cw0, ccwc - ccw0}), 32'h0505);
        $display("test pulse count done");

        // Direction level frozen while a train is busy
        apb(1'b1, PPTM_OFS_CTRL, 32'h0000_0011);
        dir <= 4'h0;
        idle(4);
        chk(32'(o[2]), 32'h0);
        @(posedge pclk);
        busy <= 4'h9;
        dir  <= 4'h9;
        idle(4);
        chk(32'(o[2]), 32'h0);
        @(posedge pclk);
        busy <= 4'h0;
        idle(4);
        chk(32'(o[2]), 32'h1);
        $display("test direction hold done");

        // Reset in mid-run clears terminals and registers
        @(posedge pclk);
        presetn <= 1'b0;
        idle(2);
        chk(32'(o), 32'h0);
        chk(32'({org, prox, inp, nin}), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PPTM_OFS_CTRL, 32'h0);
        chk(rd_q, 32'(PPTM_CTRL_RST));
        $display("test mid-run reset done");
        summarize();
    end
endmodule // pptm_top_test
